// *** rtl/gtu_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the timer unit
`ifndef GTU_REGS_SVH
`define GTU_REGS_SVH

`define GTU_ADDR_CORE_CTRL 4'h0
`define GTU_ADDR_AUXA_CTRL 4'h1
`define GTU_ADDR_AUXB_CTRL 4'h2
`define GTU_ADDR_FAST_CTRL 4'h3
`define GTU_ADDR_COMP_CTRL 4'h4
`define GTU_ADDR_CAP_CTRL  4'h5
`define GTU_ADDR_CORE_CNT  4'h6
`define GTU_ADDR_AUXA_CNT  4'h7
`define GTU_ADDR_AUXB_CNT  4'h8
`define GTU_ADDR_FAST_CNT  4'h9
`define GTU_ADDR_COMP_CNT  4'hA
`define GTU_ADDR_CAPTURE_RELOAD_REGISTER    4'hB
`define GTU_ADDR_FLAGS     4'hC

`define GTU_CTRL_RST 16'h0000
`define GTU_CNT_RST  16'h0000
`define GTU_FLAGS_RST 9'h000

`define GTU_FLG_CORE_OVF 0
`define GTU_FLG_AUXA_OVF 1
`define GTU_FLG_AUXB_OVF 2
`define GTU_FLG_FAST_OVF 3
`define GTU_FLG_COMP_OVF 4
`define GTU_FLG_AUXA_CAP 5
`define GTU_FLG_AUXB_CAP 6
`define GTU_FLG_CAPTURE_RELOAD_REGISTER   7
`define GTU_FLG_INDEX    8
`define GTU_NFLAGS       9
`define GTU_RD_CORE_TGL  14
`define GTU_RD_FAST_TGL  15

// Finest count periods in system clocks, as log2 shifts of the prescaler
`define GTU_M1_MIN_CYC 4
`define GTU_M2_MIN_CYC 2
`define GTU_M1_SHIFT 4'h2
`define GTU_M2_SHIFT 4'h1

`endif

// *** rtl/gtu_pkg.sv ***
// Types shared by the general timer unit
package gtu_pkg;

	typedef enum logic [2:0] {
		GTU_TIMER   = 3'h0,
		GTU_GATED   = 3'h1,
		GTU_COUNTER = 3'h2,
		GTU_QUAD    = 3'h3,
		GTU_RELOAD  = 3'h4,
		GTU_CAPTURE = 3'h5
	} gtu_mode_t;

	typedef struct packed {
		gtu_mode_t  mode;
		logic [2:0] presc;
		logic [1:0] edge_sel;
		logic       dir_sw;
		logic       ext_dir;
		logic       run;
		logic       src_alt;
		logic       out_en;
		logic       reload_en;
		logic [1:0] rsvd;
	} gtu_ctrl_t;

	typedef struct packed {
		logic [10:0] rsvd;
		logic        clr;
		logic [1:0]  src;
		logic [1:0]  edge_sel;
	} gtu_cap_t;

	typedef struct packed {
		logic index;
		logic cap;
		logic comp_dir;
		logic comp_clk;
		logic fast_clk;
		logic auxb_clk;
		logic core_dir;
		logic core_clk;
	} gtu_pins_t;

endpackage

// *** rtl/gtu_general_timer_unit.sv ***
// General timer unit: two timer modules, capture/reload register, register port
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "gtu_regs.svh"

module gtu_general_timer_unit (
	input  wire logic              sys_clk,
	input  wire logic              arst_n,
	input  wire logic [3:0]        reg_addr,
	input  wire logic [15:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [15:0]            reg_rdata,
	input  wire gtu_pkg::gtu_pins_t ext_pins,
	output logic                   core_toggle_output_pin,
	output logic                   fast_toggle_output_pin,
	output logic                   compare_unit_clock,
	output logic [8:0]             irq_flags
);
	import gtu_pkg::*;

	function automatic logic ptick(input logic [9:0] cnt, input logic [3:0] k);
		logic [9:0] mask;
		mask = ~(10'h3FF << k);
		return (cnt & mask) == mask;
	endfunction

	function automatic logic hit(input logic [1:0] sel, input logic r, input logic f);
		return (sel[0] & r) | (sel[1] & f);
	endfunction

	function automatic logic [16:0] step(input logic [15:0] v, input logic en, input logic dn);
		logic [16:0] res;
		res = {1'b0, v};
		if (en) begin
			if (dn) begin
				res = {v == 16'h0000, v - 16'h0001};
			end else begin
				res = {v == 16'hFFFF, v + 16'h0001};
			end
		end
		return res;
	endfunction

	gtu_ctrl_t   core_ctl;
	gtu_ctrl_t   auxa_ctl;
	gtu_ctrl_t   auxb_ctl;
	gtu_ctrl_t   fast_ctl;
	gtu_ctrl_t   comp_ctl;
	gtu_cap_t    cap_ctl;
	logic [15:0] core_cnt;
	logic [15:0] auxa_cnt;
	logic [15:0] auxb_cnt;
	logic [15:0] fast_cnt;
	logic [15:0] comp_cnt;
	logic [15:0] capture_reload_register;
	logic        core_tgl;
	logic        fast_tgl;
	logic [8:0]  flags;
	logic [9:0]  pre;
	logic [7:0]  sync1;
	logic [7:0]  sync2;
	logic [7:0]  samp1;
	logic [7:0]  samp2;
	logic [7:0]  pin_vec;
	logic [7:0]  rise1;
	logic [7:0]  fall1;
	logic [7:0]  rise2;
	logic [7:0]  fall2;
	logic        tick1;
	logic        tick2;
	logic        wr_core_ctl;
	logic        wr_flags;

	assign pin_vec = ext_pins;
	assign wr_flags = reg_wr && (reg_addr == `GTU_ADDR_FLAGS);

	// Two-stage synchronisers, first stage read only by the second
	for (genvar g = 0; g < 8; g++) begin : g_sync
		always_ff @(posedge sys_clk or negedge arst_n) begin
			if (!arst_n) begin
				sync1[g] <= 1'b0;
				sync2[g] <= 1'b0;
			end else begin
				sync1[g] <= pin_vec[g];
				sync2[g] <= sync1[g];
			end
		end
	end

	// Free-running prescaler shared by every timer
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pre <= 10'h000;
		end else begin
			pre <= pre + 10'h001;
		end
	end

	assign tick1 = ptick(pre, `GTU_M1_SHIFT);
	assign tick2 = ptick(pre, `GTU_M2_SHIFT);

	// Inputs are looked at only on the module rate, so a pin can never count faster
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			samp1 <= 8'h00;
			samp2 <= 8'h00;
		end else begin
			if (tick1) begin
				samp1 <= sync2;
			end
			if (tick2) begin
				samp2 <= sync2;
			end
		end
	end

	assign rise1 = {8{tick1}} & (sync2 ^ samp1) & sync2;
	assign fall1 = {8{tick1}} & (sync2 ^ samp1) & ~sync2;
	assign rise2 = {8{tick2}} & (sync2 ^ samp2) & sync2;
	assign fall2 = {8{tick2}} & (sync2 ^ samp2) & ~sync2;

	// First module: index 0 core, 1 aux A, 2 aux B
	gtu_ctrl_t   ctl1 [3];
	logic [2:0]  c_now;
	logic [2:0]  c_old;
	logic [2:0]  c_r;
	logic [2:0]  c_f;
	logic [2:0]  d_now;
	logic [2:0]  d_old;
	logic [2:0]  en1;
	logic [2:0]  dn1;
	logic [16:0] core_nx;
	logic [16:0] auxa_nx;
	logic [16:0] auxb_nx;
	logic        tg_r;
	logic        tg_f;

	assign ctl1[0] = core_ctl;
	assign ctl1[1] = auxa_ctl;
	assign ctl1[2] = auxb_ctl;
	// Aux A clock and all aux direction inputs have no pin
	assign c_now = {sync2[2], 1'b0, sync2[0]};
	assign c_old = {samp1[2], 1'b0, samp1[0]};
	assign c_r = {rise1[2], 1'b0, rise1[0]};
	assign c_f = {fall1[2], 1'b0, fall1[0]};
	assign d_now = {2'b00, sync2[1]};
	assign d_old = {2'b00, samp1[1]};

	// Toggle latch transitions in the cycle of the core overflow
	assign tg_r = core_nx[16] & ~core_tgl;
	assign tg_f = core_nx[16] & core_tgl;

	for (genvar i = 0; i < 3; i++) begin : g_mod1
		logic [3:0] k;
		logic       ev;
		logic       qstep;
		assign k = {1'b0, ctl1[i].presc} + `GTU_M1_SHIFT;
		// Chained aux timers count on core toggle latch edges
		assign ev = (i != 0 && ctl1[i].src_alt) ? hit(ctl1[i].edge_sel, tg_r, tg_f)
			: hit(ctl1[i].edge_sel, c_r[i], c_f[i]);
		assign qstep = tick1 & ((c_now[i] ^ c_old[i]) | (d_now[i] ^ d_old[i]));
		always_comb begin
			unique case (ctl1[i].mode)
				GTU_TIMER: en1[i] = ctl1[i].run & ptick(pre, k);
				GTU_GATED: en1[i] = ctl1[i].run & ptick(pre, k)
					& (c_now[i] == ctl1[i].edge_sel[0]);
				GTU_COUNTER: en1[i] = ctl1[i].run & ev;
				GTU_QUAD: en1[i] = ctl1[i].run & qstep;
				GTU_RELOAD: en1[i] = 1'b0;
				GTU_CAPTURE: en1[i] = 1'b0;
				default: en1[i] = 1'b0;
			endcase
		end
		// Quadrature: up when new A differs from old B
		assign dn1[i] = (ctl1[i].mode == GTU_QUAD) ? ~(c_now[i] ^ d_old[i])
			: (ctl1[i].ext_dir ? d_now[i] : ctl1[i].dir_sw);
	end

	assign core_nx = step(core_cnt, en1[0], dn1[0]);
	assign auxa_nx = step(auxa_cnt, en1[1], dn1[1]);
	assign auxb_nx = step(auxb_cnt, en1[2], dn1[2]);

	logic rel_a;
	logic rel_b;
	logic cap_a;
	logic cap_b;

	assign rel_a = (auxa_ctl.mode == GTU_RELOAD) & (auxa_ctl.src_alt
		? hit(auxa_ctl.edge_sel, tg_r, tg_f) : hit(auxa_ctl.edge_sel, c_r[1], c_f[1]));
	assign rel_b = (auxb_ctl.mode == GTU_RELOAD) & (auxb_ctl.src_alt
		? hit(auxb_ctl.edge_sel, tg_r, tg_f) : hit(auxb_ctl.edge_sel, c_r[2], c_f[2]));
	assign cap_a = (auxa_ctl.mode == GTU_CAPTURE) & hit(auxa_ctl.edge_sel, c_r[1], c_f[1]);
	assign cap_b = (auxb_ctl.mode == GTU_CAPTURE) & hit(auxb_ctl.edge_sel, c_r[2], c_f[2]);

	// Second module
	logic [16:0] fast_nx;
	logic [16:0] comp_nx;
	logic        en6;
	logic        en5;
	logic        dn5;
	logic        ft_r;
	logic        ft_f;
	logic        cap_ev;

	assign en6 = fast_ctl.run & ((fast_ctl.mode == GTU_COUNTER)
		? hit(fast_ctl.edge_sel, rise2[3], fall2[3])
		: ptick(pre, {1'b0, fast_ctl.presc} + `GTU_M2_SHIFT));
	// Fast main direction input has no pin, so external direction means up
	assign fast_nx = step(fast_cnt, en6, fast_ctl.ext_dir ? 1'b0 : fast_ctl.dir_sw);
	assign ft_r = fast_nx[16] & ~fast_tgl;
	assign ft_f = fast_nx[16] & fast_tgl;
	assign en5 = comp_ctl.run & ((comp_ctl.mode == GTU_COUNTER)
		? (comp_ctl.src_alt ? hit(comp_ctl.edge_sel, ft_r, ft_f)
		: hit(comp_ctl.edge_sel, rise2[4], fall2[4]))
		: ptick(pre, {1'b0, comp_ctl.presc} + `GTU_M2_SHIFT));
	assign dn5 = comp_ctl.ext_dir ? sync2[5] : comp_ctl.dir_sw;
	assign comp_nx = step(comp_cnt, en5, dn5);
	assign cap_ev = (cap_ctl.src == 2'h0) ? hit(cap_ctl.edge_sel, rise2[6], fall2[6])
		: ((cap_ctl.src[0] & hit(cap_ctl.edge_sel, rise2[0], fall2[0]))
		| (cap_ctl.src[1] & hit(cap_ctl.edge_sel, rise2[1], fall2[1])));

	// Control registers
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			core_ctl <= gtu_ctrl_t'(`GTU_CTRL_RST);
			auxa_ctl <= gtu_ctrl_t'(`GTU_CTRL_RST);
			auxb_ctl <= gtu_ctrl_t'(`GTU_CTRL_RST);
			fast_ctl <= gtu_ctrl_t'(`GTU_CTRL_RST);
			comp_ctl <= gtu_ctrl_t'(`GTU_CTRL_RST);
			cap_ctl  <= gtu_cap_t'(`GTU_CTRL_RST);
		end else if (reg_wr) begin
			unique case (reg_addr)
				`GTU_ADDR_CORE_CTRL: core_ctl <= gtu_ctrl_t'(reg_wdata);
				`GTU_ADDR_AUXA_CTRL: auxa_ctl <= gtu_ctrl_t'(reg_wdata);
				`GTU_ADDR_AUXB_CTRL: auxb_ctl <= gtu_ctrl_t'(reg_wdata);
				`GTU_ADDR_FAST_CTRL: fast_ctl <= gtu_ctrl_t'(reg_wdata);
				`GTU_ADDR_COMP_CTRL: comp_ctl <= gtu_ctrl_t'(reg_wdata);
				`GTU_ADDR_CAP_CTRL:  cap_ctl  <= gtu_cap_t'({11'h000, reg_wdata[4:0]});
				default: ;
			endcase
		end
	end

	// Core timer; a software write beats a reload
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			core_cnt <= `GTU_CNT_RST;
		end else if (reg_wr && reg_addr == `GTU_ADDR_CORE_CNT) begin
			core_cnt <= reg_wdata;
		end else if (rel_a) begin
			core_cnt <= auxa_cnt;
		end else if (rel_b) begin
			core_cnt <= auxb_cnt;
		end else begin
			core_cnt <= core_nx[15:0];
		end
	end

	// Auxiliary timers
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			auxa_cnt <= `GTU_CNT_RST;
			auxb_cnt <= `GTU_CNT_RST;
		end else begin
			if (reg_wr && reg_addr == `GTU_ADDR_AUXA_CNT) begin
				auxa_cnt <= reg_wdata;
			end else if (cap_a) begin
				auxa_cnt <= core_cnt;
			end else begin
				auxa_cnt <= auxa_nx[15:0];
			end
			if (reg_wr && reg_addr == `GTU_ADDR_AUXB_CNT) begin
				auxb_cnt <= reg_wdata;
			end else if (cap_b) begin
				auxb_cnt <= core_cnt;
			end else begin
				auxb_cnt <= auxb_nx[15:0];
			end
		end
	end

	// Toggle latches
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			core_tgl <= 1'b0;
			fast_tgl <= 1'b0;
		end else begin
			core_tgl <= core_tgl ^ core_nx[16];
			fast_tgl <= fast_tgl ^ fast_nx[16];
		end
	end

	// Fast main timer
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fast_cnt <= `GTU_CNT_RST;
		end else if (reg_wr && reg_addr == `GTU_ADDR_FAST_CNT) begin
			fast_cnt <= reg_wdata;
		end else if (fast_nx[16] && fast_ctl.reload_en) begin
			fast_cnt <= capture_reload_register;
		end else begin
			fast_cnt <= fast_nx[15:0];
		end
	end

	// Companion timer; clear on capture reads the old value first
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			comp_cnt <= `GTU_CNT_RST;
		end else if (reg_wr && reg_addr == `GTU_ADDR_COMP_CNT) begin
			comp_cnt <= reg_wdata;
		end else if (cap_ev && cap_ctl.clr) begin
			comp_cnt <= 16'h0000;
		end else begin
			comp_cnt <= comp_nx[15:0];
		end
	end

	// Capture/reload register
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			capture_reload_register <= `GTU_CNT_RST;
		end else if (cap_ev) begin
			capture_reload_register <= comp_cnt;
		end else if (reg_wr && reg_addr == `GTU_ADDR_CAPTURE_RELOAD_REGISTER) begin
			capture_reload_register <= reg_wdata;
		end
	end

	// Sticky event flags, write one to clear, a new event wins
	logic [8:0] flag_set;
	logic [8:0] flag_clr;

	assign flag_set = {rise1[7] | rise2[7] & ~tick1, cap_ev, cap_b, cap_a, comp_nx[16],
		fast_nx[16], auxb_nx[16], auxa_nx[16], core_nx[16]};
	assign flag_clr = wr_flags ? reg_wdata[8:0] : 9'h000;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			flags <= `GTU_FLAGS_RST;
		end else begin
			flags <= (flags & ~flag_clr) | flag_set;
		end
	end

	// Compare unit clock pulse, one cycle per fast overflow
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			compare_unit_clock <= 1'b0;
		end else begin
			compare_unit_clock <= fast_nx[16];
		end
	end

	// Registered toggle pins; disabled pins sit low
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			core_toggle_output_pin <= 1'b0;
			fast_toggle_output_pin <= 1'b0;
		end else begin
			core_toggle_output_pin <= (core_tgl ^ core_nx[16]) & core_ctl.out_en;
			fast_toggle_output_pin <= (fast_tgl ^ fast_nx[16]) & fast_ctl.out_en;
		end
	end

	assign irq_flags = flags;

	// Read port: data valid only in the cycle after the strobe
	logic [15:0] rd_mux;

	always_comb begin
		rd_mux = 16'h0000;
		unique case (reg_addr)
			`GTU_ADDR_CORE_CTRL: rd_mux = core_ctl;
			`GTU_ADDR_AUXA_CTRL: rd_mux = auxa_ctl;
			`GTU_ADDR_AUXB_CTRL: rd_mux = auxb_ctl;
			`GTU_ADDR_FAST_CTRL: rd_mux = fast_ctl;
			`GTU_ADDR_COMP_CTRL: rd_mux = comp_ctl;
			`GTU_ADDR_CAP_CTRL:  rd_mux = cap_ctl;
			`GTU_ADDR_CORE_CNT:  rd_mux = core_cnt;
			`GTU_ADDR_AUXA_CNT:  rd_mux = auxa_cnt;
			`GTU_ADDR_AUXB_CNT:  rd_mux = auxb_cnt;
			`GTU_ADDR_FAST_CNT:  rd_mux = fast_cnt;
			`GTU_ADDR_COMP_CNT:  rd_mux = comp_cnt;
			`GTU_ADDR_CAPTURE_RELOAD_REGISTER:    rd_mux = capture_reload_register;
			`GTU_ADDR_FLAGS: begin
				rd_mux[8:0] = flags;
				rd_mux[`GTU_RD_CORE_TGL] = core_tgl;
				rd_mux[`GTU_RD_FAST_TGL] = fast_tgl;
			end
			default: rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 16'h0000;
		end
	end

endmodule
`default_nettype wire

// *** testbench/gtu_general_timer_unit_monitor.sv ***
// Port checker for the general timer unit
`timescale 1ns/1ps
`default_nettype none
module gtu_monitor (
	input wire logic        sys_clk,
	input wire logic        arst_n,
	input wire logic [3:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        core_toggle_output_pin,
	input wire logic        fast_toggle_output_pin,
	input wire logic        compare_unit_clock,
	input wire logic [8:0]  irq_flags
);
	logic fl_rd;
	assign fl_rd = reg_rd && reg_addr == 4'hC;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	property p_idle;
		!$past(reg_rd) |-> reg_rdata == 16'h0000;
	endproperty
	a_idle: assert property (p_idle) else $error("read data not idle");
	property p_unmap;
		reg_rd && reg_addr > 4'hC |=> reg_rdata == 16'h0000;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_sticky;
		!(reg_wr && reg_addr == 4'hC) |=> (irq_flags & $past(irq_flags)) == $past(irq_flags);
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag lost");
	property p_flags_rd;
		fl_rd |=> reg_rdata[8:0] == $past(irq_flags);
	endproperty
	a_flags_rd: assert property (p_flags_rd) else $error("flag read differs");
	property p_core_tgl;
		fl_rd && core_toggle_output_pin |=> reg_rdata[14];
	endproperty
	a_core_tgl: assert property (p_core_tgl) else $error("core pin vs latch");
	property p_fast_tgl;
		fl_rd && fast_toggle_output_pin |=> reg_rdata[15];
	endproperty
	a_fast_tgl: assert property (p_fast_tgl) else $error("fast pin vs latch");
	property p_cuc;
		compare_unit_clock |=> !compare_unit_clock;
	endproperty
	a_cuc: assert property (p_cuc) else $error("compare clock too long");
	property p_cuc_flag;
		compare_unit_clock && !$past(reg_wr) |-> irq_flags[3];
	endproperty
	a_cuc_flag: assert property (p_cuc_flag) else $error("compare clock w/o flag");
endmodule
bind gtu_general_timer_unit gtu_monitor gtu_monitor_i (
	.sys_clk                (sys_clk),
	.arst_n                 (arst_n),
	.reg_addr               (reg_addr),
	.reg_wr                 (reg_wr),
	.reg_rd                 (reg_rd),
	.reg_rdata              (reg_rdata),
	.core_toggle_output_pin (core_toggle_output_pin),
	.fast_toggle_output_pin (fast_toggle_output_pin),
	.compare_unit_clock     (compare_unit_clock),
	.irq_flags              (irq_flags)
);
`default_nettype wire

// *** testbench/gtu_sensor_model.sv ***
// Pulse source, gate and quadrature sensor on the timer pins
`timescale 1ns/1ps
`default_nettype none
module gtu_sensor_model (
	input wire logic           sys_clk,
	output gtu_pkg::gtu_pins_t pins
);
	import gtu_pkg::*;
	int ph = 0;
	initial pins = '0;
	// Levels held 8 clocks: sync plus slowest tick
	task automatic set_pin(input int b, input logic v);
		@(posedge sys_clk);
		pins[b] <= v;
	endtask
	task automatic pulse(input int b, input int n);
		for (int i = 0; i < n; i++) begin
			repeat (8) @(posedge sys_clk);
			pins[b] <= 1'b1;
			repeat (8) @(posedge sys_clk);
			pins[b] <= 1'b0;
		end
		repeat (8) @(posedge sys_clk);
	endtask
	// Gray steps: phase A on clock pin, B on direction pin
	task automatic quad(input int n, input bit fwd);
		for (int i = 0; i < n; i++) begin
			repeat (8) @(posedge sys_clk);
			ph = fwd ? (ph + 1) % 4 : (ph + 3) % 4;
			pins[0] <= ph == 1 || ph == 2;
			pins[1] <= ph >= 2;
		end
	endtask
endmodule
`default_nettype wire

// *** testbench/test_gtu_general_timer_unit.sv ***
// Self-checking bench for the general timer unit
`timescale 1ns/1ps
`default_nettype none
module test_gtu_general_timer_unit;
	import gtu_pkg::*;
	logic        sys_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	gtu_pins_t   ext_pins;
	logic        core_pin;
	logic        fast_pin;
	logic        cuc;
	logic [8:0]  irq;
	int          err_count = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          cuc_seen = 0;
	int          pin_hi = 0;
	int          e;
	logic [15:0] seed = 16'h0015;
	logic [15:0] v;
	logic [15:0] r;
	gtu_general_timer_unit gtu_general_timer_unit_i (
		.sys_clk                (sys_clk),
		.arst_n                 (arst_n),
		.reg_addr               (reg_addr),
		.reg_wdata              (reg_wdata),
		.reg_wr                 (reg_wr),
		.reg_rd                 (reg_rd),
		.reg_rdata              (reg_rdata),
		.ext_pins               (ext_pins),
		.core_toggle_output_pin (core_pin),
		.fast_toggle_output_pin (fast_pin),
		.compare_unit_clock     (cuc),
		.irq_flags              (irq)
	);
	gtu_sensor_model sensor_i (
		.sys_clk (sys_clk),
		.pins    (ext_pins)
	);
	always #20 sys_clk = ~sys_clk;
	// Ceiling well above the under 1500 clocks the run needs
	always @(posedge sys_clk) begin
		cycles++;
		if (cuc === 1'b1) cuc_seen++;
		if (core_pin === 1'b1) pin_hi++;
		if (cycles == 20000) begin
			err_count++;
			conclude();
		end
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask
	// Count change over exactly cyc clocks between two reads
	task automatic delta(input logic [3:0] a, input int cyc, output logic [15:0] d);
		logic [15:0] p;
		logic [15:0] q;
		rd(a, p);
		repeat (cyc - 2) @(posedge sys_clk);
		rd(a, q);
		d = q - p;
	endtask
	task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
		total_checks++;
		if (g !== x) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd(4'hD, r);
		chk("unmapped", 16'h0000, r);
		wr(4'h6, 16'hFFFE);
		wr(4'h0, 16'h0028);
		repeat (20) @(posedge sys_clk);
		rd(4'hC, r);
		chk("ovf_flag", 16'h4001, r & 16'h4001);
		chk("core_pin", 16'h0001, {15'h0, core_pin});
		wr(4'hC, 16'h01FF);
		rd(4'hC, r);
		chk("flag_clr", 16'h0000, r & 16'h0001);
		for (int p = 0; p < 3; p++) begin
			wr(4'h0, 16'h0020 | 16'(p << 10));
			wr(4'h3, 16'h0020 | 16'(p << 10));
			delta(4'h6, 80, r);
			chk("core_rate", 16'(80 / (4 << p)), r);
			delta(4'h9, 80, r);
			chk("fast_rate", 16'(80 / (2 << p)), r);
		end
		wr(4'h3, 16'h0000);
		wr(4'h6, 16'h8000);
		wr(4'h0, 16'h00A0);
		delta(4'h6, 40, r);
		chk("core_down", 16'hFFF6, r);
		sensor_i.set_pin(1, 1'b1);
		wr(4'h0, 16'h0060);
		repeat (4) @(posedge sys_clk);
		delta(4'h6, 40, r);
		chk("dir_pin", 16'hFFF6, r);
		sensor_i.set_pin(1, 1'b0);
		wr(4'h0, 16'h2120);
		delta(4'h6, 40, r);
		chk("gate_low", 16'h0000, r);
		sensor_i.set_pin(0, 1'b1);
		repeat (4) @(posedge sys_clk);
		delta(4'h6, 40, r);
		chk("gate_high", 16'h000A, r);
		sensor_i.set_pin(0, 1'b0);
		wr(4'h6, 16'h0000);
		wr(4'h0, 16'h4120);
		seed = lfsr(seed);
		e = seed[2:0] + 1;
		sensor_i.pulse(0, e);
		rd(4'h6, r);
		chk("events", 16'(e), r);
		wr(4'h6, 16'h0000);
		wr(4'h0, 16'h6020);
		sensor_i.quad(10, 1'b1);
		// Back to phase 0 so both pins idle low for the capture scenarios
		sensor_i.quad(6, 1'b0);
		repeat (8) @(posedge sys_clk);
		rd(4'h6, r);
		chk("quad", 16'h0004, r);
		wr(4'h0, 16'h0000);
		seed = lfsr(seed);
		wr(4'hA, seed);
		wr(4'h4, 16'h4020);
		wr(4'h5, 16'h0011);
		sensor_i.pulse(6, 1);
		rd(4'hB, r);
		chk("capture_reload_register", seed, r);
		rd(4'hA, r);
		chk("comp_clr", 16'h0000, r);
		sensor_i.pulse(7, 1);
		rd(4'hC, r);
		chk("cap_flag", 16'h0180, r & 16'h0180);
		for (int s = 1; s < 3; s++) begin
			seed = lfsr(seed);
			wr(4'hA, seed);
			wr(4'h5, 16'(s << 2) | 16'h0001);
			sensor_i.pulse(s - 1, 1);
			rd(4'hB, r);
			chk("cap_src", seed, r);
			rd(4'hA, r);
			chk("comp_kept", seed, r);
		end
		seed = lfsr(seed);
		wr(4'h6, seed);
		wr(4'h2, 16'hA120);
		sensor_i.pulse(2, 1);
		rd(4'h8, r);
		chk("aux_cap", seed, r);
		rd(4'hC, r);
		chk("auxb_flag", 16'h0040, r & 16'h0040);
		wr(4'h2, 16'h0000);
		// Reload on either toggle edge; small slack for tick phase
		seed = lfsr(seed);
		v = {1'b0, seed[14:0]};
		wr(4'h7, v);
		wr(4'h1, 16'h8330);
		wr(4'h6, 16'hFFFE);
		wr(4'h0, 16'h0020);
		repeat (20) @(posedge sys_clk);
		rd(4'h6, r);
		chk("reload", 16'h0001, 16'((r - v) < 16'h0008));
		rd(4'h7, r);
		chk("aux_stop", v, r);
		// Aux A reloads on latch rise, aux B on fall: 8 high, 16 low
		wr(4'h1, 16'h8130);
		wr(4'h2, 16'h8230);
		wr(4'h7, 16'hFFFE);
		wr(4'h8, 16'hFFFC);
		wr(4'h6, 16'hFFFE);
		wr(4'h0, 16'h0028);
		repeat (40) @(posedge sys_clk);
		@(negedge sys_clk);
		e = pin_hi;
		repeat (96) @(negedge sys_clk);
		chk("pwm_high", 16'h0020, 16'(pin_hi - e));
		wr(4'h0, 16'h0000);
		seed = lfsr(seed);
		v = {1'b0, seed[14:0]};
		wr(4'hB, v);
		wr(4'hA, 16'h0000);
		wr(4'h4, 16'h4330);
		e = cuc_seen;
		wr(4'h9, 16'hFFFE);
		wr(4'h3, 16'h002C);
		repeat (20) @(posedge sys_clk);
		rd(4'h9, r);
		chk("fast_reload", 16'h0001, 16'((r - v) < 16'h0010));
		chk("cmp_clock", 16'h0001, 16'(cuc_seen - e));
		chk("fast_pin", 16'h0001, {15'h0, fast_pin});
		rd(4'hA, r);
		chk("comp_chain", 16'h0001, r);
		rd(4'hC, r);
		chk("fast_flag", 16'h8008, r & 16'h8008);
		conclude();
	end
endmodule
`default_nettype wire
